// file: logic/hcl_pkg.sv
package hcl_pkg;
   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 25;
   localparam int TICK_US       = 100;
   localparam int TICK_CYC      = (TICK_US * 1000) / CLK_PERIOD_NS;
   localparam int CAL_TIME_MS   = 100;
   localparam int CAL_TICKS     = (CAL_TIME_MS * 1000) / TICK_US;
   localparam logic [2:0] BOOST_HALF = 3'h4;
   // ---------------------------------------------------------------
   // Register offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_DRIVE  = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_PERIOD = 8'h0C;
   localparam logic [7:0] OFS_COMP   = 8'h10;
   localparam logic [7:0] OFS_NORM   = 8'h14;
   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int CTRL_LRA_BIT   = 0;
   localparam int CTRL_AFB_BIT   = 1;
   localparam int CTRL_ULIM_LSB  = 2;
   localparam int CTRL_CAL_BIT   = 4;
   localparam int CTRL_RATIO_LSB = 5;
   localparam int DRV_TIME_LSB   = 0;
   localparam int DRV_ZC_LSB     = 8;
   localparam int DRV_RATED_LSB  = 16;
   localparam int DRV_CLAMP_LSB  = 24;
   localparam int ST_SYNC_BIT    = 0;
   localparam int ST_OL_BIT      = 1;
   localparam int ST_LATCH_BIT   = 2;
   localparam int ST_BUSY_BIT    = 3;
   localparam int ST_VALID_BIT   = 4;
   localparam int BYTE_LSB       = 0;
   // ---------------------------------------------------------------
   // Reset values and scaling
   // ---------------------------------------------------------------
   localparam logic [4:0] DRIVE_TIME_RST = 5'h14;
   localparam logic [1:0] ZC_TIME_RST    = 2'h1;
   localparam logic [7:0] RATED_RST      = 8'h50;
   localparam logic [7:0] CLAMP_RST      = 8'hA0;
   localparam logic [2:0] RATIO_RST      = 3'h1;
   localparam logic [7:0] NORM_UNITY     = 8'h80;
   localparam int NORM_SHIFT  = 7;
   localparam int COMP_SHIFT  = 8;
   localparam int LEVEL_SHIFT = 8;
   localparam int RATIO_SHIFT = 2;
   localparam int MEM_COMP    = 0;
   localparam int MEM_NORM    = 1;
   typedef enum logic [1:0] {
      CAL_IDLE = 2'b00,
      CAL_RUN  = 2'b01,
      CAL_SAVE = 2'b11
   } cal_e;
endpackage

// file: logic/cal_store.sv
`timescale 1ns/1ps
module cal_store #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4,
   localparam int AW   = $clog2(DEPTH)
) (
   // Clock
   input  logic             clk,
   // Write port
   input  logic             we,
   input  logic [AW-1:0]    waddr,
   input  logic [WIDTH-1:0] wdata,
   // Registered read port
   input  logic [AW-1:0]    raddr,
   output logic [WIDTH-1:0] rdata
);
   logic [WIDTH-1:0] mem [DEPTH];

   if (DEPTH < 2) begin : g_chk
      $error("cal_store needs at least two words");
   end

   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule

// file: logic/haptic_loop.sv
// What this block does
// - Lock after half cycle, track each half
// - Tracking runs regardless of level calibration
// - Bad back-EMF forces open-loop overdrive
// - Zero crossing with valid back-EMF returns to closed loop
// - Fallback half period is drive minus detect
// - Optional permanent open loop on sync failure
// - Two-bit limit of unsynchronized cycles
// - Permanent open loop drops overdrive, braking
// - Higher loop gain during startup
// - Brake ratio scales braking feedback gain
// - Calibration scales to rated and clamp
// - Full-scale input gives rated level when loss factor is zero
// - Output never exceeds the clamp level
// - Calibration stores resistive-loss factor
// - Calibration stores back-EMF normalization
// - Shutdown pin low clears all state but the calibration store
//
// The register addresses and register access over APB were left to the implementer.
`timescale 1ns/1ps
module haptic_loop #(
   parameter int CAL_TICKS = hcl_pkg::CAL_TICKS,
   parameter int MEM_DEPTH = 4
) (
   // Clock and reset
   input  logic        CLK,
   input  logic        RESET,
   input  logic        SHUTDOWN_PIN_N,
   // APB slave
   input  logic        PSEL,
   input  logic        PENABLE,
   input  logic        PWRITE,
   input  logic [7:0]  PADDR,
   input  logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic        PREADY,
   output logic        PSLVERR,
   // Actuator sense
   input  logic        ZERO_CROSS,
   input  logic        BEMF_OK,
   input  logic [7:0]  BEMF_MAG,
   input  logic [7:0]  ISENSE,
   // Playback
   input  logic        PLAY,
   input  logic        BRAKE,
   input  logic [7:0]  LEVEL,
   // Drive
   output logic [7:0]  DRIVE_LEVEL,
   output logic        DRIVE_POL,
   output logic        SYNCED,
   output logic        OPEN_LOOP,
   output logic        FALLBACK_LATCHED
);
   localparam int CW  = $clog2(CAL_TICKS + 1);
   localparam int MAW = $clog2(MEM_DEPTH);
   localparam logic [11:0]   TICK_LAST = 12'(hcl_pkg::TICK_CYC - 1);
   localparam logic [CW-1:0] CAL_LAST  = CW'(CAL_TICKS - 1);

   if (CAL_TICKS < 2 || hcl_pkg::TICK_CYC > 4096) begin : g_chk
      $error("haptic_loop: unsupported count");
   end

   typedef struct packed {
      logic [31:0]     prdata;
      logic            pready;
      logic            pslverr;
      logic            act_lra;
      logic            auto_fb;
      logic [1:0]      ulimit;
      logic [2:0]      ratio;
      logic [4:0]      drive_time;
      logic [1:0]      zc_time;
      logic [7:0]      rated;
      logic [7:0]      clamp;
      logic [11:0]     tick_cnt;
      logic [7:0]      hp_cnt;
      logic [7:0]      res_period;
      logic            seen_zc;
      logic            synced;
      logic            ol_temp;
      logic            ol_latched;
      logic [2:0]      unsync;
      logic            pol;
      logic            pol_out;
      logic [2:0]      boost;
      hcl_pkg::cal_e   st;
      logic [CW-1:0]   cal_cnt;
      logic [7:0]      comp;
      logic [7:0]      norm;
      logic            cal_valid;
      logic [7:0]      drive;
      logic            mem_we;
      logic [MAW-1:0]  mem_wa;
      logic [7:0]      mem_wd;
   } state_s;

   state_s      s_ff;
   state_s      nxt_s;
   logic        rst;
   logic        tick;
   logic        hit;
   logic        wr;
   logic        wr_ctrl;
   logic        active;
   logic        timeout;
   logic [7:0]  ol_half;
   logic [7:0]  limit;
   logic [7:0]  tgt_c;
   logic [7:0]  bemf_n;
   logic [7:0]  mem_rd;
   logic [31:0] rd;
   int          target;
   int          err;

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [7:0] fn_clip(input int v,
                                          input logic [7:0] lim);
      if (v < 0) return 8'h00;
      if (v > int'(lim)) return lim;
      return 8'(v);
   endfunction

   function automatic logic [7:0] fn_half(input logic [4:0] dt,
                                          input logic [1:0] zc);
      int d;
      d = int'(dt) - int'(zc);
      return (d < 1) ? 8'h01 : 8'(d);
   endfunction

   function automatic logic fn_hit(input logic [7:0] a);
      case (a)
         hcl_pkg::OFS_CTRL, hcl_pkg::OFS_DRIVE, hcl_pkg::OFS_STATUS,
         hcl_pkg::OFS_PERIOD, hcl_pkg::OFS_COMP,
         hcl_pkg::OFS_NORM: return 1'b1;
         default:           return 1'b0;
      endcase
   endfunction

   assign rst = RESET || !SHUTDOWN_PIN_N;

   cal_store #(.WIDTH(8), .DEPTH(MEM_DEPTH)) cal_store_inst (
      .clk   (CLK),
      .we    (s_ff.mem_we),
      .waddr (s_ff.mem_wa),
      .wdata (s_ff.mem_wd),
      .raddr (MAW'(PADDR[2])),
      .rdata (mem_rd)
   );

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      nxt_s   = s_ff;
      tick    = (s_ff.tick_cnt == TICK_LAST);
      hit     = fn_hit(PADDR);
      wr      = PSEL && PENABLE && s_ff.pready && PWRITE && hit;
      wr_ctrl = wr && (PADDR == hcl_pkg::OFS_CTRL);
      active  = s_ff.act_lra && PLAY;
      ol_half = fn_half(s_ff.drive_time, s_ff.zc_time);
      limit   = (s_ff.ol_temp || !BEMF_OK) ? ol_half
                                           : {3'h0, s_ff.drive_time};
      timeout = tick && (s_ff.hp_cnt + 8'h01 >= limit);
      target  = (int'(LEVEL) * int'(s_ff.rated) + int'(s_ff.rated))
                >>> hcl_pkg::LEVEL_SHIFT;
      tgt_c   = fn_clip(target + ((target * int'(s_ff.comp))
                >>> hcl_pkg::COMP_SHIFT), s_ff.clamp);
      bemf_n  = fn_clip((int'(BEMF_MAG) * int'(s_ff.norm))
                >>> hcl_pkg::NORM_SHIFT, 8'hFF);
      err     = int'(tgt_c) - int'(bemf_n);
      rd      = '0;
      nxt_s.tick_cnt = tick ? 12'h000 : s_ff.tick_cnt + 12'h001;
      nxt_s.mem_we   = 1'b0;
      nxt_s.pready   = 1'b0;
      nxt_s.pslverr  = 1'b0;

      // Register read mux
      case (PADDR)
         hcl_pkg::OFS_CTRL: begin
            rd[hcl_pkg::CTRL_LRA_BIT] = s_ff.act_lra;
            rd[hcl_pkg::CTRL_AFB_BIT] = s_ff.auto_fb;
            rd[hcl_pkg::CTRL_ULIM_LSB +: 2] = s_ff.ulimit;
            rd[hcl_pkg::CTRL_RATIO_LSB +: 3] = s_ff.ratio;
         end
         hcl_pkg::OFS_DRIVE: begin
            rd[hcl_pkg::DRV_TIME_LSB +: 5] = s_ff.drive_time;
            rd[hcl_pkg::DRV_ZC_LSB +: 2] = s_ff.zc_time;
            rd[hcl_pkg::DRV_RATED_LSB +: 8] = s_ff.rated;
            rd[hcl_pkg::DRV_CLAMP_LSB +: 8] = s_ff.clamp;
         end
         hcl_pkg::OFS_STATUS: begin
            rd[hcl_pkg::ST_SYNC_BIT] = s_ff.synced;
            rd[hcl_pkg::ST_OL_BIT] = s_ff.ol_temp;
            rd[hcl_pkg::ST_LATCH_BIT] = s_ff.ol_latched;
            rd[hcl_pkg::ST_BUSY_BIT] = (s_ff.st != hcl_pkg::CAL_IDLE);
            rd[hcl_pkg::ST_VALID_BIT] = s_ff.cal_valid;
         end
         hcl_pkg::OFS_PERIOD: rd[hcl_pkg::BYTE_LSB +: 8] = s_ff.res_period;
         hcl_pkg::OFS_COMP, hcl_pkg::OFS_NORM: begin
            rd[hcl_pkg::BYTE_LSB +: 8] = s_ff.cal_valid ? mem_rd : 8'h00;
         end
         default: rd = '0;
      endcase

      // APB: one wait state, answer in second access cycle
      if (PSEL && PENABLE && !s_ff.pready) begin
         nxt_s.pready  = 1'b1;
         nxt_s.pslverr = !hit;
         nxt_s.prdata  = rd;
      end
      if (wr_ctrl) begin
         nxt_s.act_lra = PWDATA[hcl_pkg::CTRL_LRA_BIT];
         nxt_s.auto_fb = PWDATA[hcl_pkg::CTRL_AFB_BIT];
         nxt_s.ulimit  = PWDATA[hcl_pkg::CTRL_ULIM_LSB +: 2];
         nxt_s.ratio   = PWDATA[hcl_pkg::CTRL_RATIO_LSB +: 3];
         if (!PWDATA[hcl_pkg::CTRL_AFB_BIT]) begin
            nxt_s.ol_latched = 1'b0;
         end
      end
      if (wr && PADDR == hcl_pkg::OFS_DRIVE) begin
         nxt_s.drive_time = PWDATA[hcl_pkg::DRV_TIME_LSB +: 5];
         nxt_s.zc_time    = PWDATA[hcl_pkg::DRV_ZC_LSB +: 2];
         nxt_s.rated      = PWDATA[hcl_pkg::DRV_RATED_LSB +: 8];
         nxt_s.clamp      = PWDATA[hcl_pkg::DRV_CLAMP_LSB +: 8];
      end

      // Resonance tracking, independent of calibration
      if (!PLAY) begin
         nxt_s.boost = hcl_pkg::BOOST_HALF;
      end else if (!s_ff.act_lra && tick && s_ff.boost != 3'h0) begin
         nxt_s.boost = s_ff.boost - 3'h1;
      end
      if (!active) begin
         nxt_s.hp_cnt  = 8'h00;
         nxt_s.seen_zc = 1'b0;
         nxt_s.synced  = 1'b0;
         nxt_s.ol_temp = 1'b0;
         nxt_s.unsync  = 3'h0;
         nxt_s.pol     = 1'b0;
      end else if (s_ff.ol_latched) begin
         if (tick) nxt_s.hp_cnt = s_ff.hp_cnt + 8'h01;
         if (timeout) begin
            nxt_s.hp_cnt = 8'h00;
            nxt_s.pol    = !s_ff.pol;
         end
      end else begin
         if (tick) nxt_s.hp_cnt = s_ff.hp_cnt + 8'h01;
         if (!BEMF_OK) begin
            nxt_s.ol_temp = 1'b1;
            nxt_s.synced  = 1'b0;
         end
         if (ZERO_CROSS && BEMF_OK) begin
            nxt_s.res_period = s_ff.hp_cnt;
            nxt_s.hp_cnt     = 8'h00;
            nxt_s.synced     = s_ff.seen_zc;
            nxt_s.seen_zc    = 1'b1;
            nxt_s.ol_temp    = 1'b0;
            nxt_s.unsync     = 3'h0;
            nxt_s.pol        = !s_ff.pol;
            if (s_ff.boost != 3'h0) nxt_s.boost = s_ff.boost - 3'h1;
         end else if (timeout) begin
            nxt_s.hp_cnt  = 8'h00;
            nxt_s.pol     = !s_ff.pol;
            nxt_s.synced  = 1'b0;
            nxt_s.ol_temp = 1'b1;
            if (s_ff.boost != 3'h0) nxt_s.boost = s_ff.boost - 3'h1;
            if (s_ff.unsync != 3'h7) nxt_s.unsync = s_ff.unsync + 3'h1;
            if (s_ff.auto_fb && s_ff.unsync >= {1'b0, s_ff.ulimit}) begin
               nxt_s.ol_latched = 1'b1;
            end
         end
      end

      // Level calibration
      case (s_ff.st)
         hcl_pkg::CAL_IDLE: begin
            if (wr_ctrl && PWDATA[hcl_pkg::CTRL_CAL_BIT]) begin
               nxt_s.st        = hcl_pkg::CAL_RUN;
               nxt_s.cal_cnt   = '0;
               nxt_s.norm      = hcl_pkg::NORM_UNITY;
               nxt_s.comp      = 8'h00;
               nxt_s.cal_valid = 1'b0;
            end
         end
         hcl_pkg::CAL_RUN: begin
            if (tick) begin
               nxt_s.cal_cnt = s_ff.cal_cnt + CW'(1);
               if (bemf_n < s_ff.rated && s_ff.norm != 8'hFF) begin
                  nxt_s.norm = s_ff.norm + 8'h01;
               end else if (bemf_n > s_ff.rated && s_ff.norm != 8'h01) begin
                  nxt_s.norm = s_ff.norm - 8'h01;
               end
               if (s_ff.cal_cnt == CAL_LAST) begin
                  nxt_s.st     = hcl_pkg::CAL_SAVE;
                  nxt_s.comp   = ISENSE;
                  nxt_s.mem_we = 1'b1;
                  nxt_s.mem_wa = MAW'(hcl_pkg::MEM_COMP);
                  nxt_s.mem_wd = ISENSE;
               end
            end
         end
         hcl_pkg::CAL_SAVE: begin
            nxt_s.st        = hcl_pkg::CAL_IDLE;
            nxt_s.mem_we    = 1'b1;
            nxt_s.mem_wa    = MAW'(hcl_pkg::MEM_NORM);
            nxt_s.mem_wd    = s_ff.norm;
            nxt_s.cal_valid = 1'b1;
         end
         default: nxt_s.st = hcl_pkg::CAL_IDLE;
      endcase

      // Drive level, always inside the clamp
      nxt_s.pol_out = s_ff.pol;
      if (s_ff.st != hcl_pkg::CAL_IDLE) begin
         nxt_s.drive = fn_clip(int'(s_ff.rated), s_ff.clamp);
      end else if (!PLAY) begin
         nxt_s.drive = 8'h00;
      end else if (s_ff.ol_latched) begin
         nxt_s.drive = BRAKE ? 8'h00 : tgt_c;
      end else if (s_ff.ol_temp && s_ff.act_lra) begin
         nxt_s.drive = s_ff.clamp;
      end else if (BRAKE) begin
         nxt_s.drive = fn_clip(int'(bemf_n) + ((int'(bemf_n)
            * int'(s_ff.ratio)) >>> hcl_pkg::RATIO_SHIFT),
            s_ff.clamp);
         nxt_s.pol_out = !s_ff.pol;
      end else begin
         nxt_s.drive = fn_clip(int'(tgt_c) + ((s_ff.boost != 3'h0)
            ? 2 * err : err), s_ff.clamp);
      end
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (rst) begin
         s_ff            <= '0;
         s_ff.drive_time <= hcl_pkg::DRIVE_TIME_RST;
         s_ff.zc_time    <= hcl_pkg::ZC_TIME_RST;
         s_ff.rated      <= hcl_pkg::RATED_RST;
         s_ff.clamp      <= hcl_pkg::CLAMP_RST;
         s_ff.ratio      <= hcl_pkg::RATIO_RST;
         s_ff.norm       <= hcl_pkg::NORM_UNITY;
         s_ff.boost      <= hcl_pkg::BOOST_HALF;
         s_ff.st         <= hcl_pkg::CAL_IDLE;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign PRDATA           = s_ff.prdata;
   assign PREADY           = s_ff.pready;
   assign PSLVERR          = s_ff.pslverr;
   assign DRIVE_LEVEL      = s_ff.drive;
   assign DRIVE_POL        = s_ff.pol_out;
   assign SYNCED           = s_ff.synced;
   assign OPEN_LOOP        = s_ff.ol_temp;
   assign FALLBACK_LATCHED = s_ff.ol_latched;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (rst);

   logic zc_ok;
   assign zc_ok = active && !s_ff.ol_latched && ZERO_CROSS && BEMF_OK;

   lock_half_a: assert property (zc_ok && s_ff.seen_zc |=> SYNCED)
      else $error("no lock after half cycle");
   period_cap_a: assert property (zc_ok |=>
      s_ff.res_period == $past(s_ff.hp_cnt))
      else $error("period not captured");
   fallback_a: assert property (active && !BEMF_OK &&
      !s_ff.ol_latched |=> OPEN_LOOP && !SYNCED)
      else $error("no fallback on bad back-EMF");
   resume_a: assert property (zc_ok |=> !OPEN_LOOP)
      else $error("closed loop not resumed");
   overdrive_a: assert property (s_ff.ol_temp && s_ff.act_lra && PLAY
      && !s_ff.ol_latched && s_ff.st == hcl_pkg::CAL_IDLE
      |=> DRIVE_LEVEL == $past(s_ff.clamp))
      else $error("fallback not in overdrive");
   clamp_lim_a: assert property (##1 DRIVE_LEVEL <= $past(s_ff.clamp))
      else $error("drive above clamp");
   latch_cnt_a: assert property ($rose(FALLBACK_LATCHED) |->
      $past(s_ff.auto_fb) && $past(s_ff.unsync) == {1'b0, $past(s_ff.ulimit)})
      else $error("latched at wrong count");
   latch_hold_a: assert property (FALLBACK_LATCHED && !wr_ctrl
      |=> FALLBACK_LATCHED)
      else $error("permanent open loop left");
   no_brake_a: assert property (FALLBACK_LATCHED && PLAY && BRAKE &&
      s_ff.st == hcl_pkg::CAL_IDLE |=> DRIVE_LEVEL == 8'h00)
      else $error("braking in open loop");
   full_scale_a: assert property (FALLBACK_LATCHED && PLAY && !BRAKE
      && LEVEL == 8'hFF && s_ff.comp == 8'h00 && s_ff.rated <= s_ff.clamp
      && s_ff.st == hcl_pkg::CAL_IDLE |=> DRIVE_LEVEL == $past(s_ff.rated))
      else $error("full scale not rated");
   cal_comp_a: assert property ($rose(s_ff.st == hcl_pkg::CAL_SAVE)
      |-> s_ff.comp == $past(ISENSE) ##1 s_ff.cal_valid)
      else $error("loss factor not stored");
   shutdown_a: assert property (@(posedge CLK) disable iff (RESET)
      !SHUTDOWN_PIN_N |=> DRIVE_LEVEL == 8'h00 && !SYNCED && !PREADY)
      else $error("shutdown not clearing");

   sync_c: cover property ($rose(SYNCED));
   latch_c: cover property ($rose(FALLBACK_LATCHED));
   cal_c: cover property ($rose(s_ff.cal_valid));
   brake_c: cover property (PLAY && BRAKE && DRIVE_LEVEL != 8'h00);
endmodule

// file: bench/actuator_model.sv
`timescale 1ns/1ps
module actuator_model #(
   parameter int         HALF_CYC = 4000,
   parameter logic [7:0] RESIST   = 8'h2A
) (
   // Clock
   input  wire logic       clk,
   // Bench control
   input  wire logic       moving,
   input  wire logic       bemf_good,
   input  wire logic [7:0] mag,
   // Sense outputs
   output logic            zero_cross,
   output logic            bemf_ok,
   output logic [7:0]      bemf_mag,
   output logic [7:0]      isense
);
   int cnt_ff;
   initial begin
      cnt_ff = 0;
      zero_cross = 1'b0;
      bemf_ok = 1'b1;
      bemf_mag = 8'h00;
      isense = 8'h00;
   end
   // Crossing pulses only while the mass moves
   always @(posedge clk) begin
      cnt_ff <= (cnt_ff == HALF_CYC - 1) ? 0 : cnt_ff + 1;
      zero_cross <= moving && (cnt_ff == HALF_CYC - 1);
      bemf_ok <= bemf_good;
      // Invalid back-EMF gives a changing pattern, not the last value
      bemf_mag <= bemf_good ? mag : ~bemf_mag;
      isense <= RESIST;
   end
endmodule

// file: bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   localparam int          TK  = hcl_pkg::TICK_CYC;
   localparam logic [7:0]  ACT = hcl_pkg::OFS_CTRL;
   localparam logic [7:0]  ADR = hcl_pkg::OFS_DRIVE;
   localparam logic [7:0]  AST = hcl_pkg::OFS_STATUS;
   localparam logic [31:0] DRV = 32'hA050_0103;
   logic        clk     = 1'b0;
   logic        reset   = 1'b1;
   logic        shut_n  = 1'b1;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [7:0]  paddr   = 8'h00;
   logic [31:0] pwdata  = 32'h0;
   logic        play    = 1'b0;
   logic        brake   = 1'b0;
   logic [7:0]  level   = 8'hFF;
   logic        moving  = 1'b0;
   logic        good    = 1'b1;
   logic [7:0]  mag     = 8'h40;
   logic [31:0] prdata, rd;
   logic        pready, pslverr, er, zc, bok, dpol, synced, olp, latched;
   logic [7:0]  bmag, isen, dlvl;
   int          miscompares = 0;
   int          tests_run   = 0;
   int          cyc         = 0;
   int          c0;
   always #12.5 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;
   haptic_loop #(.CAL_TICKS(4), .MEM_DEPTH(4)) haptic_loop_inst (
      .CLK(clk), .RESET(reset), .SHUTDOWN_PIN_N(shut_n), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .ZERO_CROSS(zc), .BEMF_OK(bok), .BEMF_MAG(bmag), .ISENSE(isen),
      .PLAY(play), .BRAKE(brake), .LEVEL(level), .DRIVE_LEVEL(dlvl),
      .DRIVE_POL(dpol), .SYNCED(synced), .OPEN_LOOP(olp),
      .FALLBACK_LATCHED(latched));
   actuator_model actuator_model_inst (
      .clk(clk), .moving(moving), .bemf_good(good), .mag(mag),
      .zero_cross(zc), .bemf_ok(bok), .bemf_mag(bmag), .isense(isen));
   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic final_report();
      if (miscompares == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] got, exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic fail_out(input string nm);
      miscompares++;
      $display("[ERR] %s expected done seen timeout", nm);
      final_report();
   endtask
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      // Answer taken at the rising edge where pready is sampled high
      do begin
         @(posedge clk);
         n++;
         if (n > 50) fail_out("pready");
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rchk(input string nm, input logic [7:0] a,
                       input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(nm, rd, exp);
   endtask
   function automatic logic sig(input int s);
      case (s)
         0: return synced;
         1: return olp;
         2: return latched;
         default: return dpol;
      endcase
   endfunction
   task automatic wait_for(input string nm, input int s, input logic v,
                           input int lim);
      int n;
      n = 0;
      while (sig(s) !== v) begin
         @(negedge clk);
         n++;
         if (n > lim) fail_out(nm);
      end
   endtask
   task automatic lvl(input string nm, input logic [7:0] exp);
      repeat (3) @(negedge clk);
      chk(nm, 32'(dlvl), 32'(exp));
   endtask
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic s_regs();
      rchk("ctrl_rst", ACT, 32'h0000_0020);
      rchk("drive_rst", ADR, 32'hA050_0114);
      rchk("comp_rst", hcl_pkg::OFS_COMP, 32'h0);
      rchk("norm_rst", hcl_pkg::OFS_NORM, 32'h0);
      apb(1'b1, AST, 32'h0000_001F);
      rchk("status_ro", AST, 32'h0);
      rchk("unmapped", 8'h18, 32'h0);
      chk("unmapped_err", 32'(er), 32'h1);
      apb(1'b0, 8'h02, 32'h0);
      chk("unaligned_err", 32'(er), 32'h1);
      apb(1'b1, ADR, DRV);
      rchk("drive_wr", ADR, DRV);
   endtask
   task automatic s_track();
      apb(1'b1, ACT, 32'h21);
      @(posedge clk);
      moving <= 1'b1;
      play <= 1'b1;
      wait_for("lock", 0, 1'b1, 2 * TK + 10);
      rchk("sync_st", AST, 32'h1);
      rchk("period", hcl_pkg::OFS_PERIOD, 32'h1);
   endtask
   task automatic s_fallback();
      @(posedge clk);
      good <= 1'b0;
      wait_for("ol_enter", 1, 1'b1, 3);
      lvl("ol_drive", 8'hA0);
      wait_for("pol_a", 3, ~dpol, 4 * TK);
      c0 = cyc;
      wait_for("pol_b", 3, ~dpol, 4 * TK);
      chk("ol_half", 32'(cyc - c0), 32'(2 * TK));
      @(posedge clk);
      good <= 1'b1;
      wait_for("relock", 0, 1'b1, 3 * TK);
      chk("ol_exit", 32'(olp), 32'h0);
      @(posedge clk);
      play <= 1'b0;
      moving <= 1'b0;
   endtask
   task automatic s_latch();
      apb(1'b1, ACT, 32'h27);
      @(posedge clk);
      play <= 1'b1;
      wait_for("miss_1", 1, 1'b1, 4 * TK);
      chk("no_latch", 32'(latched), 32'h0);
      wait_for("latch", 2, 1'b1, 3 * TK);
      lvl("latch_lvl", 8'h50);
      @(posedge clk);
      brake <= 1'b1;
      lvl("latch_brk", 8'h00);
      @(posedge clk);
      brake <= 1'b0;
      moving <= 1'b1;
      repeat (2 * TK) @(negedge clk);
      chk("no_resync", 32'(synced), 32'h0);
      chk("stay_latch", 32'(latched), 32'h1);
      apb(1'b1, ACT, 32'h21);
      lvl("unlatch_lvl", 8'hA0);
      chk("unlatch", 32'(latched), 32'h0);
      @(posedge clk);
      play <= 1'b0;
      moving <= 1'b0;
   endtask
   task automatic s_erm();
      apb(1'b1, ACT, 32'h20);
      @(posedge clk);
      play <= 1'b1;
      lvl("boost", 8'h70);
      repeat (5 * TK) @(negedge clk);
      lvl("steady", 8'h60);
      @(posedge clk);
      mag <= 8'h50;
      lvl("rated", 8'h50);
      @(posedge clk);
      mag <= 8'h40;
      brake <= 1'b1;
      lvl("brk_1", 8'h50);
      apb(1'b1, ACT, 32'h60);
      lvl("brk_3", 8'h70);
      @(posedge clk);
      brake <= 1'b0;
      mag <= 8'h00;
      lvl("clamp", 8'hA0);
      @(posedge clk);
      play <= 1'b0;
      mag <= 8'h40;
      lvl("idle", 8'h00);
   endtask
   task automatic s_cal();
      int n;
      n = 0;
      apb(1'b1, ACT, 32'h30);
      lvl("cal_lvl", 8'h50);
      do begin
         apb(1'b0, AST, 32'h0);
         n++;
         if (n > 5000) fail_out("cal_done");
      end while (rd[hcl_pkg::ST_VALID_BIT] !== 1'b1);
      rchk("comp", hcl_pkg::OFS_COMP, 32'h2A);
      rchk("norm", hcl_pkg::OFS_NORM, 32'h84);
      @(posedge clk);
      play <= 1'b1;
      lvl("cal_play", 8'h93);
      @(posedge clk);
      shut_n <= 1'b0;
      lvl("shutdown", 8'h00);
      @(posedge clk);
      shut_n <= 1'b1;
      play <= 1'b0;
      rchk("norm_clr", hcl_pkg::OFS_NORM, 32'h0);
      rchk("ctrl_clr", ACT, 32'h20);
   endtask
   initial begin
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      s_regs();
      s_track();
      s_fallback();
      s_latch();
      s_erm();
      s_cal();
      final_report();
   end
endmodule
